// file: design/sar_adc_pkg.sv
/*
 * Shared constants and carrier types for the converter control block.
 * Assumes an 8-bit special-function register port and a 25 MHz system clock.
 */
package sar_adc_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_CONFIG    = 8'hbc;
   localparam logic [7:0] ADDR_RES_LOW   = 8'hbe;
   localparam logic [7:0] ADDR_RES_HIGH  = 8'hbf;
   localparam logic [7:0] ADDR_GT_LOW    = 8'hc4;
   localparam logic [7:0] ADDR_GT_HIGH   = 8'hc5;
   localparam logic [7:0] ADDR_LT_LOW    = 8'hc6;
   localparam logic [7:0] ADDR_LT_HIGH   = 8'hc7;
   localparam logic [7:0] ADDR_CONTROL   = 8'he8;

   // Reset values
   localparam logic [7:0] RST_CONFIG     = 8'h60;
   localparam logic [7:0] RST_CONTROL    = 8'h00;
   localparam logic [7:0] RST_RESULT     = 8'h00;
   localparam logic [7:0] RST_GT         = 8'hff;
   localparam logic [7:0] RST_LT_LOW     = 8'h00;
   localparam logic [7:0] RST_LT_HIGH    = 8'h00;

   // Config register fields
   localparam int CFG_DIV_HI   = 7;
   localparam int CFG_DIV_LO   = 5;
   localparam int CFG_GAIN_HI  = 2;
   localparam int CFG_GAIN_LO  = 0;
   localparam logic [7:0] CFG_WRITE_MASK = 8'he7;

   // Control register bit positions
   localparam int CTL_ENABLE   = 7;
   localparam int CTL_TRACK    = 6;
   localparam int CTL_DONE     = 5;
   localparam int CTL_BUSY     = 4;
   localparam int CTL_SRC_HI   = 3;
   localparam int CTL_SRC_LO   = 2;
   localparam int CTL_WINDOW   = 1;
   localparam int CTL_LJUST    = 0;

   // Start sources
   localparam logic [1:0] SRC_SOFTWARE = 2'h0;
   localparam logic [1:0] SRC_TIMER3   = 2'h1;
   localparam logic [1:0] SRC_EXTERNAL = 2'h2;
   localparam logic [1:0] SRC_TIMER2   = 2'h3;

   // Timing
   localparam int TRACK_SAR_CLKS   = 3;
   localparam int SYS_CLK_KHZ      = 25000;
   localparam int SAR_CLK_MAX_KHZ  = 2000;
   localparam int MIN_SAR_DIV      = (SYS_CLK_KHZ + SAR_CLK_MAX_KHZ - 1) / SAR_CLK_MAX_KHZ;
   localparam int RESULT_BITS      = 10;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sfr_req_t;

   // Raw result from the analog core
   typedef struct packed {
      logic [RESULT_BITS-1:0] data;
      logic                   diff;
   } sar_result_t;

   // One-hot gain select: {half, x16, x8, x4, x2, x1}
   typedef logic [5:0] gain_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_TRACK   = 3'h2,
      ST_CONVERT = 3'h4
   } conv_state_t;

endpackage : sar_adc_pkg

// file: design/sar_clock_divider.sv
/*
 * Conversion clock enable generator.
 * Assumes the caller restarts it at each start so periods align to the start.
 */
`timescale 1ns/1ps
module sar_clock_divider (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] div_code,
   input  wire logic       restart,
   output logic            sar_tick
);

   logic [3:0] count_q;
   logic [3:0] last;

   // 1xx saturates at sixteen system clocks
   always_comb begin
      if (div_code[2]) begin
         last = 4'hf;
      end else begin
         last = 4'((5'h1 << div_code[1:0]) - 5'h1);
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Free counter, one-cycle pulse at the end of each period
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_q  <= 4'h0;
         sar_tick <= 1'b0;
      end else if (restart) begin
         // The start cycle is the first of the period, so the first tick lands
         // one full period later and tracking lasts whole SAR periods
         count_q  <= (last == 4'h0) ? 4'h0 : 4'h1;
         sar_tick <= last == 4'h0;
      end else if (count_q >= last) begin
         count_q  <= 4'h0;
         sar_tick <= 1'b1;
      end else begin
         count_q  <= count_q + 4'h1;
         sar_tick <= 1'b0;
      end
   end

endmodule : sar_clock_divider

// file: design/sar_adc_control.sv
/*
 * Control, result formatting and window detector for a 10-bit SAR converter.
 * Assumes timer overflows and the analog result are on clk; the external
 * start pin is asynchronous. Registers sit on an 8-bit register port.
 */
`timescale 1ns/1ps
module sar_adc_control #(
   parameter int CONV_SAR_CLKS = 16
) (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire sar_adc_pkg::sfr_req_t    sfr,
   output logic [7:0]                    sfr_rdata,
   input  wire logic                     timer3_overflow,
   input  wire logic                     timer2_overflow,
   input  wire logic                     external_convert_start,
   input  wire sar_adc_pkg::sar_result_t sar_in,
   output logic                          converter_powered,
   output logic                          track_active,
   output logic                          convert_active,
   output logic                          sar_clk_en,
   output sar_adc_pkg::gain_t            amp_gain,
   output logic                          conv_complete_req,
   output logic                          window_match_req
);

   localparam int CW = $clog2(CONV_SAR_CLKS + 1);
   localparam logic [CW-1:0] CONV_LAST  = CW'(CONV_SAR_CLKS - 1);
   localparam logic [CW-1:0] TRACK_LAST = CW'(sar_adc_pkg::TRACK_SAR_CLKS - 1);

   // Configuration fields
   logic [2:0]  sar_clock_divider_q;
   logic [2:0]  amp_gain_select_q;

   // Control fields
   logic        converter_enable_q;
   logic        track_mode_select_q;
   logic        conversion_done_flag_q;
   logic [1:0]  start_source_select_q;
   logic        window_match_flag_q;
   logic        left_justify_select_q;

   // Data and limits
   logic [7:0]  result_low_byte_q;
   logic [7:0]  result_high_byte_q;
   logic [15:0] greater_limit_q;
   logic [15:0] less_limit_q;

   // Sequencer
   sar_adc_pkg::conv_state_t state_q;
   logic [CW-1:0]            clk_count_q;

   // External start synchroniser
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic ext_level_q;
   logic ext_rise;

   logic        wr_config;
   logic        wr_control;
   logic        sw_start;
   logic        start_ev;
   logic        done_ev;
   logic        sar_tick;
   logic        busy;
   logic [15:0] fmt_word;
   logic        win_hit;
   logic        track_d;

   //////////////////////////////////////////////////////////////////////
   // Write decode
   always_comb begin
      wr_config  = 1'b0;
      wr_control = 1'b0;
      if (sfr.wr && sfr.addr == sar_adc_pkg::ADDR_CONFIG) begin
         wr_config = 1'b1;
      end else if (sfr.wr && sfr.addr == sar_adc_pkg::ADDR_CONTROL) begin
         wr_control = 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // External start pin: three flops, level changes once stages two and
   // three agree, so a single glitch sample is never taken as an edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ext_s1_q    <= 1'b0;
         ext_s2_q    <= 1'b0;
         ext_s3_q    <= 1'b0;
         ext_level_q <= 1'b0;
      end else begin
         ext_s1_q <= external_convert_start;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         if (ext_s2_q == ext_s3_q) begin
            ext_level_q <= ext_s3_q;
         end
      end
   end

   assign ext_rise = ext_s2_q & ext_s3_q & ~ext_level_q;

   //////////////////////////////////////////////////////////////////////
   // Start selection; the source code carried by the same write decides
   // whether a busy write counts, so one write can both select and start
   assign sw_start = wr_control && sfr.wdata[sar_adc_pkg::CTL_BUSY] &&
                     sfr.wdata[sar_adc_pkg::CTL_SRC_HI:sar_adc_pkg::CTL_SRC_LO]
                        == sar_adc_pkg::SRC_SOFTWARE;

   always_comb begin
      start_ev = 1'b0;
      case (start_source_select_q)
         sar_adc_pkg::SRC_SOFTWARE: start_ev = sw_start;
         sar_adc_pkg::SRC_TIMER3:   start_ev = timer3_overflow;
         sar_adc_pkg::SRC_EXTERNAL: start_ev = ext_rise;
         default:                   start_ev = timer2_overflow;
      endcase
      // A busy write is judged by the source code it carries, not the stored one
      start_ev = start_ev | sw_start;
      // Starts count only when enabled and idle
      if (!converter_enable_q || state_q != sar_adc_pkg::ST_IDLE) begin
         start_ev = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Conversion clock, realigned on every start so tracking lasts whole
   // SAR periods
   sar_clock_divider u_div (
      .clk      (clk),
      .resetn   (resetn),
      .div_code (sar_clock_divider_q),
      .restart  (start_ev),
      .sar_tick (sar_tick)
   );

   assign sar_clk_en = sar_tick;

   //////////////////////////////////////////////////////////////////////
   // Sequencer: idle, optional three-clock track, then convert
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= sar_adc_pkg::ST_IDLE;
         clk_count_q <= '0;
      end else if (!converter_enable_q) begin
         state_q     <= sar_adc_pkg::ST_IDLE;
         clk_count_q <= '0;
      end else begin
         case (state_q)
            sar_adc_pkg::ST_IDLE: begin
               clk_count_q <= '0;
               if (start_ev) begin
                  if (track_mode_select_q &&
                      start_source_select_q != sar_adc_pkg::SRC_EXTERNAL) begin
                     state_q <= sar_adc_pkg::ST_TRACK;
                  end else begin
                     state_q <= sar_adc_pkg::ST_CONVERT;
                  end
               end
            end
            sar_adc_pkg::ST_TRACK: begin
               if (sar_tick) begin
                  if (clk_count_q == TRACK_LAST) begin
                     clk_count_q <= '0;
                     state_q     <= sar_adc_pkg::ST_CONVERT;
                  end else begin
                     clk_count_q <= clk_count_q + 1'b1;
                  end
               end
            end
            sar_adc_pkg::ST_CONVERT: begin
               if (sar_tick) begin
                  if (clk_count_q == CONV_LAST) begin
                     clk_count_q <= '0;
                     state_q     <= sar_adc_pkg::ST_IDLE;
                  end else begin
                     clk_count_q <= clk_count_q + 1'b1;
                  end
               end
            end
            default: begin
               state_q     <= sar_adc_pkg::ST_IDLE;
               clk_count_q <= '0;
            end
         endcase
      end
   end

   // Busy covers track and convert; it falls as the result lands
   assign busy    = state_q != sar_adc_pkg::ST_IDLE;
   assign done_ev = converter_enable_q && state_q == sar_adc_pkg::ST_CONVERT &&
                    sar_tick && clk_count_q == CONV_LAST;

   //////////////////////////////////////////////////////////////////////
   // Analog side controls
   always_comb begin
      track_d = 1'b0;
      if (converter_enable_q) begin
         if (!track_mode_select_q) begin
            track_d = state_q != sar_adc_pkg::ST_CONVERT;
         end else if (start_source_select_q == sar_adc_pkg::SRC_EXTERNAL) begin
            track_d = !ext_level_q && state_q != sar_adc_pkg::ST_CONVERT;
         end else begin
            track_d = state_q == sar_adc_pkg::ST_TRACK;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         track_active      <= 1'b0;
         convert_active    <= 1'b0;
         converter_powered <= 1'b0;
      end else begin
         track_active      <= track_d;
         convert_active    <= converter_enable_q && state_q == sar_adc_pkg::ST_CONVERT;
         converter_powered <= converter_enable_q;
      end
   end

   // Gain decode; 10x and 11x ignore their low bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         amp_gain <= 6'h01;
      end else if (amp_gain_select_q[2]) begin
         amp_gain <= amp_gain_select_q[1] ? 6'h20 : 6'h10;
      end else begin
         amp_gain <= 6'(6'h01 << amp_gain_select_q[1:0]);
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Result formatting in the justification selected at completion
   always_comb begin
      if (left_justify_select_q) begin
         fmt_word = {sar_in.data, 6'h00};
      end else begin
         fmt_word = {{6{sar_in.diff & sar_in.data[9]}}, sar_in.data};
      end
   end

   // Window compare; signedness follows the channel type. The test is
   // strict, so equal limits flag everything except the limit itself.
   always_comb begin
      logic lt_above;
      logic below_lt;
      logic above_gt;
      lt_above = 1'b0;
      below_lt = 1'b0;
      above_gt = 1'b0;
      if (sar_in.diff) begin
         lt_above = $signed(less_limit_q) > $signed(greater_limit_q);
         below_lt = $signed(fmt_word) < $signed(less_limit_q);
         above_gt = $signed(fmt_word) > $signed(greater_limit_q);
      end else begin
         lt_above = less_limit_q > greater_limit_q;
         below_lt = fmt_word < less_limit_q;
         above_gt = fmt_word > greater_limit_q;
      end
      if (lt_above) begin
         win_hit = below_lt & above_gt;
      end else begin
         win_hit = below_lt | above_gt;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Result registers: completion outranks a software write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         result_low_byte_q  <= sar_adc_pkg::RST_RESULT;
         result_high_byte_q <= sar_adc_pkg::RST_RESULT;
      end else if (done_ev) begin
         result_high_byte_q <= fmt_word[15:8];
         result_low_byte_q  <= fmt_word[7:0];
      end else if (sfr.wr) begin
         if (sfr.addr == sar_adc_pkg::ADDR_RES_LOW) begin
            result_low_byte_q <= sfr.wdata;
         end else if (sfr.addr == sar_adc_pkg::ADDR_RES_HIGH) begin
            result_high_byte_q <= sfr.wdata;
         end
      end
   end

   // Limit words
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         greater_limit_q <= {sar_adc_pkg::RST_GT, sar_adc_pkg::RST_GT};
         less_limit_q    <= {sar_adc_pkg::RST_LT_HIGH, sar_adc_pkg::RST_LT_LOW};
      end else if (sfr.wr) begin
         if (sfr.addr == sar_adc_pkg::ADDR_GT_LOW) begin
            greater_limit_q[7:0] <= sfr.wdata;
         end else if (sfr.addr == sar_adc_pkg::ADDR_GT_HIGH) begin
            greater_limit_q[15:8] <= sfr.wdata;
         end else if (sfr.addr == sar_adc_pkg::ADDR_LT_LOW) begin
            less_limit_q[7:0] <= sfr.wdata;
         end else if (sfr.addr == sar_adc_pkg::ADDR_LT_HIGH) begin
            less_limit_q[15:8] <= sfr.wdata;
         end
      end
   end

   // Configuration; unused bits are never stored
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sar_clock_divider_q <= sar_adc_pkg::RST_CONFIG[sar_adc_pkg::CFG_DIV_HI:
                                                        sar_adc_pkg::CFG_DIV_LO];
         amp_gain_select_q   <= sar_adc_pkg::RST_CONFIG[sar_adc_pkg::CFG_GAIN_HI:
                                                        sar_adc_pkg::CFG_GAIN_LO];
      end else if (wr_config) begin
         sar_clock_divider_q <= sfr.wdata[sar_adc_pkg::CFG_DIV_HI:sar_adc_pkg::CFG_DIV_LO];
         amp_gain_select_q   <= sfr.wdata[sar_adc_pkg::CFG_GAIN_HI:sar_adc_pkg::CFG_GAIN_LO];
      end
   end

   // Control fields
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         converter_enable_q    <= sar_adc_pkg::RST_CONTROL[sar_adc_pkg::CTL_ENABLE];
         track_mode_select_q   <= sar_adc_pkg::RST_CONTROL[sar_adc_pkg::CTL_TRACK];
         start_source_select_q <= sar_adc_pkg::RST_CONTROL[sar_adc_pkg::CTL_SRC_HI:
                                                           sar_adc_pkg::CTL_SRC_LO];
         left_justify_select_q <= sar_adc_pkg::RST_CONTROL[sar_adc_pkg::CTL_LJUST];
      end else if (wr_control) begin
         converter_enable_q    <= sfr.wdata[sar_adc_pkg::CTL_ENABLE];
         track_mode_select_q   <= sfr.wdata[sar_adc_pkg::CTL_TRACK];
         start_source_select_q <= sfr.wdata[sar_adc_pkg::CTL_SRC_HI:sar_adc_pkg::CTL_SRC_LO];
         left_justify_select_q <= sfr.wdata[sar_adc_pkg::CTL_LJUST];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Sticky flags: hardware set wins over a clearing write in one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conversion_done_flag_q <= sar_adc_pkg::RST_CONTROL[sar_adc_pkg::CTL_DONE];
      end else if (done_ev) begin
         conversion_done_flag_q <= 1'b1;
      end else if (wr_control) begin
         conversion_done_flag_q <= sfr.wdata[sar_adc_pkg::CTL_DONE];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         window_match_flag_q <= sar_adc_pkg::RST_CONTROL[sar_adc_pkg::CTL_WINDOW];
      end else if (done_ev && win_hit) begin
         window_match_flag_q <= 1'b1;
      end else if (wr_control) begin
         window_match_flag_q <= sfr.wdata[sar_adc_pkg::CTL_WINDOW];
      end
   end

   // Request pulses toward the interrupt controller, which applies enables
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conv_complete_req <= 1'b0;
         window_match_req  <= 1'b0;
      end else begin
         conv_complete_req <= done_ev;
         window_match_req  <= done_ev & win_hit;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Read port: data one cycle after the read strobe, zero when unmapped
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata <= 8'h00;
      end else if (!sfr.rd) begin
         sfr_rdata <= 8'h00;
      end else if (sfr.addr == sar_adc_pkg::ADDR_CONFIG) begin
         sfr_rdata <= {sar_clock_divider_q, 2'h0, amp_gain_select_q};
      end else if (sfr.addr == sar_adc_pkg::ADDR_CONTROL) begin
         sfr_rdata <= {converter_enable_q, track_mode_select_q, conversion_done_flag_q,
                       busy, start_source_select_q, window_match_flag_q,
                       left_justify_select_q};
      end else if (sfr.addr == sar_adc_pkg::ADDR_RES_LOW) begin
         sfr_rdata <= result_low_byte_q;
      end else if (sfr.addr == sar_adc_pkg::ADDR_RES_HIGH) begin
         sfr_rdata <= result_high_byte_q;
      end else if (sfr.addr == sar_adc_pkg::ADDR_GT_LOW) begin
         sfr_rdata <= greater_limit_q[7:0];
      end else if (sfr.addr == sar_adc_pkg::ADDR_GT_HIGH) begin
         sfr_rdata <= greater_limit_q[15:8];
      end else if (sfr.addr == sar_adc_pkg::ADDR_LT_LOW) begin
         sfr_rdata <= less_limit_q[7:0];
      end else if (sfr.addr == sar_adc_pkg::ADDR_LT_HIGH) begin
         sfr_rdata <= less_limit_q[15:8];
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

endmodule : sar_adc_control

// file: dv/sar_core_model.sv
/* Analog core stand-in: returns the value set by the bench while powered.
   Assumes the control block samples it only at completion. */
`timescale 1ns/1ps
module sar_core_model (
   input  wire logic                clk,
   input  wire logic                powered,
   input  wire logic [10:0]         value,
   output sar_adc_pkg::sar_result_t sar_in
);
   logic [10:0] last_q = 11'h000;
   // A shut-down core holds nothing valid, so invert the last value every cycle
   always_ff @(posedge clk) last_q <= powered ? value : ~last_q;
   assign sar_in = powered ? value : last_q;
endmodule : sar_core_model

// file: dv/sar_adc_checker.sv
/* Port assertions for the converter control.
   Assumes it is bound to every control instance. */
`timescale 1ns/1ps
module sar_adc_checker #(
   parameter int CONV_SAR_CLKS = 16
) (
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire sar_adc_pkg::sfr_req_t sfr,
   input wire logic [7:0]            sfr_rdata,
   input wire logic                  converter_powered,
   input wire logic                  track_active,
   input wire logic                  convert_active,
   input wire sar_adc_pkg::gain_t    amp_gain,
   input wire logic                  conv_complete_req,
   input wire logic                  window_match_req
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Window pulse only rides on a completion
   window_needs_done_a: assert property (window_match_req |-> conv_complete_req)
      else $error("window pulse alone");
   gain_sixteen_a: assert property (sfr.wr && sfr.addr == 8'hbc && sfr.wdata[2:1] == 2'b10
      |=> ##[0:1] amp_gain == 6'h10) else $error("gain code wrong");
   shutdown_idle_a: assert property (!converter_powered && !$past(converter_powered)
      |-> !convert_active && !track_active) else $error("active while shut down");
   track_or_convert_a: assert property (!(track_active && convert_active))
      else $error("track during convert");
   done_pulse_a: assert property (conv_complete_req |=> !conv_complete_req)
      else $error("completion pulse too long");
   done_after_convert_a: assert property (conv_complete_req
      |-> $past(convert_active) || $past(convert_active, 2)) else $error("done without convert");
   cfg_unused_zero_a: assert property (sfr.rd && sfr.addr == 8'hbc
      |=> sfr_rdata[4:3] == 2'b00) else $error("unused config bits set");
   soft_start_a: assert property (sfr.wr && sfr.addr == 8'he8 && sfr.wdata[7:6] == 2'b10
      && sfr.wdata[4:2] == 3'b100 && converter_powered && !convert_active
      |-> ##[1:4] convert_active) else $error("software start lost");
endmodule : sar_adc_checker
bind sar_adc_control sar_adc_checker #(.CONV_SAR_CLKS(CONV_SAR_CLKS)) chk (.clk, .resetn, .sfr,
   .sfr_rdata, .converter_powered, .track_active, .convert_active, .amp_gain, .conv_complete_req,
   .window_match_req);

// file: dv/sar_adc_control_tb.sv
/* Register-level bench for the converter control.
   Assumes the core model and checker are compiled alongside. */
`timescale 1ns/1ps
module sar_adc_control_tb;
   logic                      clk = 0, resetn = 0, t3 = 0, t2 = 0, ext = 0;
   logic                      powered, track, conv, creq, wreq, got, hit, tick;
   logic [7:0]                rdata, d, e;
   logic [10:0]               value = 11'h000;
   sar_adc_pkg::sfr_req_t     sfr = '0;
   sar_adc_pkg::sar_result_t  sar_in;
   sar_adc_pkg::gain_t        gain;
   int                        err_total = 0, comparisons = 0, tc = 0, tt = 0, c0, nc, nt, n0;
   int                        tk = 0, k0, nk;
   logic [7:0]  adr [9] = '{8'hbc, 8'hbe, 8'hbf, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'he8, 8'hbd};
   logic [7:0]  rst [9] = '{8'h60, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [5:0]  gns [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h10, 6'h20, 6'h20};
   int          per [6] = '{1, 2, 4, 8, 16, 16};
   logic [2:0]  dvs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   // {justify, diff, data, less limit, greater limit, result word, window hit}
   logic [60:0] win [7] = '{{2'b00, 10'h3ff, 16'h0000, 16'hffff, 16'h03ff, 1'b0},
      {2'b10, 10'h3ff, 16'h8000, 16'h4000, 16'hffc0, 1'b0},
      {2'b01, 10'h200, 16'h0100, 16'hffff, 16'hfe00, 1'b0},
      {2'b01, 10'h000, 16'h0100, 16'hffff, 16'h0000, 1'b1},
      {2'b00, 10'h150, 16'h0200, 16'h0100, 16'h0150, 1'b1},
      {2'b00, 10'h100, 16'h0200, 16'h0100, 16'h0100, 1'b0},
      {2'b00, 10'h0ff, 16'h0100, 16'h0200, 16'h00ff, 1'b1}};
   sar_adc_control #(.CONV_SAR_CLKS(4)) dut (.clk, .resetn, .sfr, .sfr_rdata(rdata),
      .timer3_overflow(t3), .timer2_overflow(t2), .external_convert_start(ext), .sar_in,
      .converter_powered(powered), .track_active(track), .convert_active(conv), .sar_clk_en(tick),
      .amp_gain(gain), .conv_complete_req(creq), .window_match_req(wreq));
   sar_core_model core (.clk, .powered, .value, .sar_in);
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and running phase counters; unknowns never count
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      if (conv === 1'b1) tc <= tc + 1;
      if (track === 1'b1) tt <= tt + 1;
      if (conv === 1'b1 && tick === 1'b1) tk <= tk + 1;
   end
   task automatic check(input string what, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Strobes drop one cycle before return, so calls never collide
   task automatic wr(input logic [7:0] a, dat);
      sfr <= '{a, dat, 1'b1, 1'b0};
      @(posedge clk) sfr <= '0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      sfr <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) sfr <= '0;
      @(posedge clk) q = rdata;
   endtask : rd
   task automatic summarize;
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // Write control, pulse the chosen start inputs, wait boundedly for completion
   task automatic run(input logic [7:0] ctl, input logic [2:0] kick, input int lim, input want);
      wr(8'he8, ctl);
      c0 = tc;
      nt = tt;
      k0 = tk;
      got = 0;
      {ext, t2, t3} <= kick;
      // The pin stays up so the three-flop filter sees a lasting edge
      @(posedge clk) {t2, t3} <= 2'h0;
      for (int i = 0; i < lim && !got; i++) @(posedge clk) if (creq === 1'b1) {got, hit} = {1'b1, wreq};
      @(posedge clk);
      nc = tc - c0;
      nt = tt - nt;
      nk = tk - k0;
      ext <= 1'b0;
      check("start", got, want);
      if (want && !got) summarize();
   endtask : run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1;
      foreach (adr[i]) begin
         rd(adr[i], d);
         check("reset value", d, rst[i]);
      end
      wr(8'hbc, 8'hff);
      rd(8'hbc, d);
      check("config", d, 8'he7);
      foreach (gns[g]) begin
         wr(8'hbc, 8'(g));
         @(posedge clk);
         check("gain", gain, gns[g]);
      end
      run(8'h10, 3'h0, 60, 1'b0);
      wr(8'he8, 8'h80);
      foreach (dvs[k]) begin
         wr(8'hbc, {dvs[k], 5'h00});
         run(8'h90, 3'h0, 400, 1'b1);
         check("sar ticks", nk, 4);
         if (k == 0) n0 = nc;
         else check("sar period", nc - n0, 4 * (per[k] - 1));
      end
      wr(8'hbc, 8'h20);
      wr(8'he8, 8'hc0);
      run(8'hd0, 3'h0, 200, 1'b1);
      check("track length", nt, 6);
      for (int s = 1; s < 4; s++) begin
         run(8'h90 | 8'(s << 2), 3'h0, 60, 1'b0);
         run(8'h80 | 8'(s << 2), s == 1 ? 3'h1 : s == 2 ? 3'h4 : 3'h2, 200, 1'b1);
      end
      wr(8'hbc, 8'h80);
      // Pin settles high under source 11 first, so selecting 10 sees no edge
      ext <= 1'b1;
      repeat (6) @(posedge clk);
      wr(8'he8, 8'hc8);
      @(posedge clk);
      check("ext track high", track, 1'b0);
      ext <= 1'b0;
      repeat (6) @(posedge clk);
      check("ext track low", track, 1'b1);
      foreach (win[j]) begin
         for (int b = 0; b < 4; b++) wr(8'hc4 + 8'(b), win[j][8 * b + 17 +: 8]);
         value <= {win[j][58:49], win[j][59]};
         run({7'h48, win[j][60]}, 3'h0, 300, 1'b1);
         check("window pulse", hit, win[j][0]);
         rd(8'hbf, d);
         rd(8'hbe, e);
         check("result word", {d, e}, win[j][16:1]);
         rd(8'he8, d);
         check("flags", {d[5], d[1]}, {1'b1, win[j][0]});
      end
      wr(8'he8, 8'h80);
      rd(8'he8, d);
      check("flag clear", d, 8'h80);
      summarize();
   end
endmodule : sar_adc_control_tb
